// ==== rtl/sarcc_control.sv ====
// Conversion control of a 16-bit successive-approximation converter.
// Assumes host pins are asynchronous; the digital result is supplied
// by the analog core on sar_result when conversion is done.
//
// Overview of operation
// - Output bus is enabled only while select and read are both low.
// - An external serial clock is ignored unless chip select is low.
// - A high reset input returns the sequencer to acquisition and aborts any conversion; shift_data keeps its value.
// - With power-down high, a running conversion ends, then none starts.
// - Start high at the end of acquisition waits for its falling edge.
// - Start already low at the end of acquisition converts at once.
// - Busy rises at conversion start and falls once the result is latched.
`timescale 1ns/1ps
`default_nettype none

module sarcc_control #(
	parameter int ACQ_CNT = sarcc_pkg::ACQ_CYCLES,
	parameter int CONV_CNT = sarcc_pkg::CONV_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire sarcc_pkg::sarcc_pins_s pins,
	input wire logic ext_serial_clk,
	input wire logic [sarcc_pkg::DATA_W-1:0] sar_result,
	output logic busy,
	output logic hold,
	output logic low_power,
	output logic bus_enable,
	output logic serial_clk_gated,
	output logic [sarcc_pkg::DATA_W-1:0] shift_data
);
	import sarcc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers; stage one is read only by stage two
	sarcc_pins_s pin_s1;
	sarcc_pins_s pin_s2;
	logic sclk_s1;
	logic sclk_s2;
	logic start_prev;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= PINS_IDLE;
			pin_s2 <= PINS_IDLE;
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			start_prev <= 1'b1;
		end else begin
			pin_s1 <= pins;
			pin_s2 <= pin_s1;
			sclk_s1 <= ext_serial_clk;
			sclk_s2 <= sclk_s1;
			start_prev <= pin_s2.conversion_start_n;
		end
	end

	logic start_fall;
	assign start_fall = start_prev && !pin_s2.conversion_start_n;

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	sarcc_state_e state;
	sarcc_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [DATA_W-1:0] next_shift_data;
	logic next_busy;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_shift_data = shift_data;
		next_busy = busy;
		if (pin_s2.reset_request) begin
			next_state = SARCC_ACQ;
			next_cnt = CNT_RESET;
			next_busy = 1'b0;
		end else begin
			case (state)
				SARCC_ACQ: begin
					if (pin_s2.power_down_request) begin
						next_state = SARCC_POWER_DOWN;
						next_cnt = CNT_RESET;
					end else if (cnt < CNT_W'(ACQ_CNT - 1)) begin
						next_cnt = cnt + 12'h001;
					end else if (!pin_s2.conversion_start_n) begin
						next_state = SARCC_CONV;
						next_cnt = CNT_RESET;
						next_busy = 1'b1;
					end else begin
						next_state = SARCC_WAIT_EDGE;
					end
				end
				SARCC_WAIT_EDGE: begin
					if (pin_s2.power_down_request) begin
						next_state = SARCC_POWER_DOWN;
						next_cnt = CNT_RESET;
					end else if (start_fall) begin
						next_state = SARCC_CONV;
						next_cnt = CNT_RESET;
						next_busy = 1'b1;
					end
				end
				SARCC_CONV: begin
					// Runs to the end even under power-down
					if (cnt < CNT_W'(CONV_CNT - 1)) begin
						next_cnt = cnt + 12'h001;
					end else begin
						next_shift_data = sar_result;
						next_busy = 1'b0;
						next_cnt = CNT_RESET;
						next_state = pin_s2.power_down_request ?
							SARCC_POWER_DOWN : SARCC_ACQ;
					end
				end
				SARCC_POWER_DOWN: begin
					// Fresh acquisition after wake, input may have drifted
					if (!pin_s2.power_down_request) begin
						next_state = SARCC_ACQ;
						next_cnt = CNT_RESET;
					end
				end
				default: begin
					next_state = SARCC_ACQ;
					next_cnt = CNT_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= SARCC_ACQ;
			cnt <= CNT_RESET;
			shift_data <= DATA_RESET;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			shift_data <= next_shift_data;
			busy <= next_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output pins
	logic next_hold;
	logic next_low_power;
	logic next_bus_enable;
	logic next_sclk_gated;

	always_comb begin
		next_hold = (next_state == SARCC_CONV);
		next_low_power = (next_state == SARCC_POWER_DOWN);
		next_bus_enable = !pin_s2.chip_select_n && !pin_s2.read_n;
		next_sclk_gated = sclk_s2 && !pin_s2.chip_select_n;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hold <= 1'b0;
			low_power <= 1'b0;
			bus_enable <= 1'b0;
			serial_clk_gated <= 1'b0;
		end else begin
			hold <= next_hold;
			low_power <= next_low_power;
			bus_enable <= next_bus_enable;
			serial_clk_gated <= next_sclk_gated;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	bus_enable_gate_a: assert property (@(posedge clk)
		disable iff (!resetn)
		bus_enable |-> !$past(pin_s2.chip_select_n) && !$past(pin_s2.read_n))
		else $error("bus enabled without select and read");
	sclk_gate_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$past(pin_s2.chip_select_n) |-> !serial_clk_gated)
		else $error("serial clock passed while deselected");
	reset_abort_a: assert property (@(posedge clk)
		disable iff (!resetn)
		pin_s2.reset_request |=> !busy && state == SARCC_ACQ)
		else $error("reset did not abort conversion");
	pd_no_start_a: assert property (@(posedge clk)
		disable iff (!resetn)
		state == SARCC_POWER_DOWN |=> !$rose(busy))
		else $error("conversion started in power-down");
	pd_finish_a: assert property (@(posedge clk)
		disable iff (!resetn)
		state == SARCC_CONV && pin_s2.power_down_request
		&& !pin_s2.reset_request && cnt != CNT_W'(CONV_CNT - 1) |=> busy)
		else $error("power-down cut a running conversion");
	low_power_idle_a: assert property (@(posedge clk)
		disable iff (!resetn)
		low_power |-> !busy && !hold)
		else $error("busy while in low power");
	wait_edge_a: assert property (@(posedge clk)
		disable iff (!resetn)
		state == SARCC_WAIT_EDGE && !start_fall |=> !busy)
		else $error("conversion without falling edge");
	edge_mode_a: assert property (@(posedge clk)
		disable iff (!resetn)
		state == SARCC_ACQ && cnt == CNT_W'(ACQ_CNT - 1)
		&& pin_s2.conversion_start_n && !pin_s2.reset_request
		&& !pin_s2.power_down_request |=> state == SARCC_WAIT_EDGE && !busy)
		else $error("start high did not wait for an edge");
	immediate_start_a: assert property (@(posedge clk)
		disable iff (!resetn)
		state == SARCC_ACQ && cnt == CNT_W'(ACQ_CNT - 1)
		&& !pin_s2.conversion_start_n && !pin_s2.reset_request
		&& !pin_s2.power_down_request |=> busy && hold)
		else $error("immediate start missed");
	busy_end_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$fell(busy) && !$past(pin_s2.reset_request) |->
		shift_data == $past(sar_result))
		else $error("busy fell without latching result");
	hold_busy_a: assert property (@(posedge clk)
		disable iff (!resetn)
		hold == busy)
		else $error("hold and busy disagree");
	reset_return_a: assert property (@(posedge clk)
		disable iff (!resetn)
		$fell(pin_s2.reset_request) |-> !busy && state == SARCC_ACQ
		&& cnt == CNT_RESET)
		else $error("not in acquisition after reset");

endmodule

`default_nettype wire

// ==== shared/sarcc_pkg.sv ====
// Package for the converter conversion-control block.
// Assumes a single 125 MHz clock and an active-low asynchronous reset.
package sarcc_pkg;

	// Timing at 125 MHz
	localparam int CLK_PERIOD_NS = 8;
	localparam int ACQ_TIME_NS = 1000;
	localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int CONV_TIME_NS = 8000;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 12;
	localparam int DATA_W = 16;

	// Reset values
	localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

	typedef enum logic [1:0] {
		SARCC_ACQ = 2'b00,
		SARCC_WAIT_EDGE = 2'b01,
		SARCC_CONV = 2'b10,
		SARCC_POWER_DOWN = 2'b11
	} sarcc_state_e;

	// Host-side control pins, asynchronous until synchronised in sarcc_control
	typedef struct packed {
		logic chip_select_n;
		logic read_n;
		logic reset_request;
		logic power_down_request;
		logic conversion_start_n;
	} sarcc_pins_s;

	// Idle host levels; any other reset value would fake a request
	localparam sarcc_pins_s PINS_IDLE = '{
		chip_select_n: 1'b1,
		read_n: 1'b1,
		reset_request: 1'b0,
		power_down_request: 1'b0,
		conversion_start_n: 1'b1
	};

endpackage

// ==== testbench/sarcc_host.sv ====
// Host model driving the converter control pins and serial clock.
// Assumes the bench calls its tasks; pins change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sarcc_host (
	input wire logic clk,
	output var sarcc_pkg::sarcc_pins_s pins,
	output logic sclk,
	output logic [15:0] result
);
	import sarcc_pkg::*;
	logic sclk_on = 1'b0;
	initial begin
		pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		sclk = 1'b0;
		result = 16'hA5C3;
	end
	// Clock stands still unless enabled
	always begin
		repeat (4) @(negedge clk);
		if (sclk_on) sclk = ~sclk;
	end
	task automatic set(input logic cs, rd, rst, pd, st);
		@(negedge clk);
		pins = '{cs, rd, rst, pd, st};
	endtask
	// Start kept high, conversion fired by an edge
	task automatic trigger();
		@(negedge clk);
		pins.conversion_start_n = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_sarcc_control.sv ====
// Self-checking bench for the conversion control block.
// Assumes short acquisition and conversion counts.
`timescale 1ns/1ps
`default_nettype none
module tb_sarcc_control;
	import sarcc_pkg::*;
	localparam int CONV = 8;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	sarcc_pins_s pins;
	logic sclk, busy, hold, low_power, bus_enable, sclk_g;
	logic [DATA_W-1:0] result, shift_data;
	int num_errors = 0;
	int n_compared = 0;
	int n;
	always #4 clk = ~clk;
	sarcc_host host (.clk(clk), .pins(pins), .sclk(sclk), .result(result));
	sarcc_control #(.ACQ_CNT(4), .CONV_CNT(CONV)) uut (.clk(clk),
		.resetn(resetn), .pins(pins), .ext_serial_clk(sclk),
		.sar_result(result), .busy(busy), .hold(hold),
		.low_power(low_power), .bus_enable(bus_enable),
		.serial_clk_gated(sclk_g), .shift_data(shift_data));
	task automatic complete_run();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// Bounded wait, n gives cycles spent
	task automatic wait_busy(input logic lvl, input int lim);
		n = 0;
		while (busy !== lvl) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				num_errors++;
				$display("[FAIL] %0t busy wait timed out", $time);
				complete_run();
			end
		end
	endtask
	task automatic sc_start_low();
		host.set(1, 1, 0, 0, 0);
		wait_busy(1, 20);
		chk(hold, 1, "hold not set");
		wait_busy(0, 20);
		chk(n, CONV, "busy length");
		chk(shift_data, 16'hA5C3, "result not latched");
	endtask
	task automatic sc_edge();
		host.set(1, 1, 0, 0, 1);
		// Watched every cycle; a stray start would end before a late look
		n = 0;
		repeat (20) begin
			@(negedge clk);
			if (busy !== 1'b0) n++;
		end
		chk(n, 0, "started without edge");
		host.trigger();
		wait_busy(1, 6);
	endtask
	task automatic sc_reset();
		repeat (2) @(negedge clk);
		chk(busy, 1, "no conversion to abort");
		host.set(1, 1, 1, 0, 1);
		// Looked at before the conversion could end by itself
		repeat (3) @(negedge clk);
		chk(busy, 0, "conversion not aborted");
		host.set(1, 1, 0, 0, 1);
		repeat (20) @(negedge clk);
		chk({busy, hold}, 0, "not back in acquisition");
		host.trigger();
		wait_busy(1, 6);
	endtask
	task automatic sc_power_down();
		host.set(1, 1, 0, 1, 0);
		wait_busy(0, CONV);
		// Request lands one cycle into the running conversion
		chk(n, CONV - 1, "conversion cut by power down");
		repeat (4) @(negedge clk);
		chk(low_power, 1, "no low power");
		repeat (20) @(negedge clk);
		chk(busy, 0, "converted in power down");
		host.set(1, 1, 0, 0, 0);
		wait_busy(1, 20);
		chk(low_power, 0, "low power after wake");
		host.set(1, 1, 0, 0, 1);
		wait_busy(0, 20);
	endtask
	task automatic sc_bus();
		for (int i = 0; i < 4; i++) begin
			host.set(i[1], i[0], 0, 0, 1);
			repeat (4) @(negedge clk);
			chk(bus_enable, i == 0, "bus enable");
		end
		host.sclk_on = 1'b1;
		for (int c = 0; c < 2; c++) begin
			host.set(c[0], 1, 0, 0, 1);
			repeat (4) @(negedge clk);
			n = 0;
			repeat (32) begin
				@(negedge clk);
				if (sclk_g === 1'b1) n++;
			end
			chk(n != 0, c == 0, "serial clock gate");
		end
		host.sclk_on = 1'b0;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		sc_start_low();
		sc_edge();
		sc_reset();
		sc_power_down();
		sc_bus();
		complete_run();
	end
endmodule
`default_nettype wire
